// ===== shared/aof_consts.vh
/*
 Constants for the converter output format and shutdown block.
 Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef AOF_CONSTS_VH
`define AOF_CONSTS_VH
`define AOF_CLK_MHZ        100
`define AOF_CONV_TYP_NS    1400
`define AOF_CONV_MAX_NS    2000
`define AOF_ACQ_MAX_NS     150
`define AOF_THRU_NS        2500
`define AOF_NAP_WAKE_NS    200
`define AOF_SLEEP_WAKE_MS  10
`define AOF_RES_W          12
`define AOF_ADDR_W         4
`define AOF_STAT_W         7
`define AOF_MID_CODE       12'h800
`endif

// ===== rtl/aof_top.v
/*
 Digital side of an eight channel sampling converter: output word, enables,
 status readback, internal conversion timing and shutdown control.
 Assumes all inputs are synchronous to i_clk and the analog core delivers a
 raw offset-binary result on i_raw_result when asked.
*/
// Overview of operation
// RULE1 - Output word is 12-bit result plus 4-bit mux address and pair bit; code sends only the result and 4-bit mux address, 16 bits.
// RULE2 - Data pins driven only while read strobe and chip select are low.
// RULE3 - Polarity select low gives straight binary coding, LSB is FS/4096.
// RULE4 - Polarity select high gives two's complement coding, LSB span/4096.
// RULE5 - Code transitions lie midway between integer LSB levels.
// RULE6 - Readback puts the 7-bit status word on the top data pins.
// RULE7 - Readback keeps the lower nine data pins undriven always.
// RULE8 - Conversion timed internally, typical 1400ns, at most 2us; code holds it in conversion past that while the result buffer is full.
// RULE9 - Acquisition within 150ns, full sample cycle 2.5us.
// RULE10 - Low shutdown input enters shutdown, high input leaves it.
// RULE11 - Chip select low while shutting down selects Nap.
// RULE12 - Nap keeps logic and reference up; host waits 200ns to convert.
// RULE13 - Host waits about 10ms after Sleep before accurate conversions.
// RULE14 - Host should hold its bus quiet or buffer it during conversions.
// RULE15 - Start low with chip select low begins a conversion, never restarted.
// RULE16 - Busy output stays low through the conversion, rises with result.
// RULE17 - Shutdown with chip select high selects Sleep, reference off.
// RULE18 - No conversion starts in either shutdown state.
`timescale 1ns/100ps
`include "aof_consts.vh"
module aof_top
#(
    parameter RES_W  = `AOF_RES_W,
    parameter ADDR_W = `AOF_ADDR_W,
    parameter STAT_W = `AOF_STAT_W
)
(
    input  wire                     i_clk,
    input  wire                     i_rst_n,
    input  wire                     i_chip_select_n,
    input  wire                     i_read_n,
    input  wire                     i_convert_start_n,
    input  wire                     i_power_down_n,
    input  wire                     i_polarity_select,
    input  wire                     i_readback_mode,
    input  wire [STAT_W-1:0]        i_sequencer_status_word,
    input  wire [ADDR_W-1:0]        i_mux_addr,
    input  wire [RES_W-1:0]         i_raw_result,
    input  wire                     i_host_ready,
    output reg  [RES_W+ADDR_W-1:0]  o_data,
    output wire [RES_W+ADDR_W-1:0]  o_data_oe_n,
    output wire                     o_busy_n,
    output wire                     o_sample,
    output wire                     o_nap,
    output wire                     o_sleep,
    output wire                     o_word_valid
);
    // ======================================================================
    // Timing counts
    // ======================================================================
    localparam CONV_CYC  = (`AOF_CONV_TYP_NS * `AOF_CLK_MHZ) / 1000;
    localparam ACQ_CYC   = (`AOF_ACQ_MAX_NS * `AOF_CLK_MHZ) / 1000;
    localparam THRU_CYC  = (`AOF_THRU_NS * `AOF_CLK_MHZ) / 1000;
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACQ  = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    localparam [1:0] ST_HOLD = 2'h3;
    localparam DW = RES_W + ADDR_W;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [8:0]  cnt_reg;
    reg  [8:0]  cnt_next;
    reg         nap_reg;
    reg         sleep_reg;
    reg         start_d_reg;
    reg  [DW-1:0] word_c;
    wire        shut;
    wire        start_fall;
    wire        buf_in_ready;
    wire        push;
    wire [DW-1:0] buf_data;
    wire        buf_valid;

    // ======================================================================
    // Shutdown control
    // ======================================================================
    // Shutdown type is latched when the shutdown input falls.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            nap_reg   <= 1'b0;
            sleep_reg <= 1'b0;
        end
        else if (i_power_down_n)
        begin
            nap_reg   <= 1'b0; // see RULE10
            sleep_reg <= 1'b0;
        end
        else if (!nap_reg && !sleep_reg)
        begin
            nap_reg   <= ~i_chip_select_n; // see RULE11 RULE12
            sleep_reg <= i_chip_select_n;  // see RULE17
        end
    end
    assign shut    = nap_reg | sleep_reg | ~i_power_down_n;
    assign o_nap   = nap_reg;
    assign o_sleep = sleep_reg;

    // ======================================================================
    // Conversion sequencer
    // ======================================================================
    // Start is the falling edge of the start input with chip select low.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            start_d_reg <= 1'b1;
        else
            start_d_reg <= i_convert_start_n;
    end
    assign start_fall = start_d_reg & ~i_convert_start_n & ~i_chip_select_n;

    // Acquire, convert, then hold out the rest of the sample cycle.
    always @*
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 9'h001;
        case (state_reg)
            ST_IDLE:
            begin
                cnt_next = 9'h000;
                if (start_fall && !shut && !i_readback_mode) // see RULE15 RULE18
                    state_next = ST_ACQ;
            end
            ST_ACQ:
                if (cnt_reg == ACQ_CYC - 1) // see RULE9
                begin
                    state_next = ST_CONV;
                    cnt_next   = 9'h000;
                end
            ST_CONV:
                if (cnt_reg == CONV_CYC - 1 && buf_in_ready) // see RULE8
                    state_next = ST_HOLD;
            ST_HOLD:
                if (cnt_reg >= THRU_CYC - ACQ_CYC - 1) // see RULE9
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 9'h000;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= (state_reg == ST_CONV && cnt_reg == CONV_CYC - 1 && !buf_in_ready)
                         ? cnt_reg : cnt_next;
        end
    end
    assign o_busy_n = ~(state_reg == ST_ACQ || state_reg == ST_CONV); // see RULE16
    assign o_sample = (state_reg == ST_ACQ);
    assign push     = (state_reg == ST_CONV) && (cnt_reg == CONV_CYC - 1);

    // ======================================================================
    // Output coding
    // ======================================================================
    // The core rounds at half-LSB thresholds; bipolar flips the sign bit.
    always @*
    begin
        word_c = {i_mux_addr, i_raw_result}; // see RULE1 RULE3 RULE5
        if (i_polarity_select)
            word_c[RES_W-1] = ~i_raw_result[RES_W-1]; // see RULE4
    end

    // ======================================================================
    // Result buffer
    // ======================================================================
    aof_buf2 #(.W(DW)) u_buf
    (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_valid   (push),
        .o_ready   (buf_in_ready),
        .i_data    (word_c),
        .o_valid   (buf_valid),
        .i_ready   (i_host_ready),
        .o_data    (buf_data)
    );
    assign o_word_valid = buf_valid;

    // ======================================================================
    // Output drivers
    // ======================================================================
    // Readback shows the status word on the top pins only.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_data <= {DW{1'b0}};
        else if (i_readback_mode)
            o_data <= {i_sequencer_status_word, {(DW-STAT_W){1'b0}}}; // see RULE6
        else if (buf_valid)
            o_data <= buf_data;
    end
    assign o_data_oe_n[DW-1:DW-STAT_W] = {STAT_W{i_read_n | i_chip_select_n}}; // see RULE2 RULE6
    assign o_data_oe_n[DW-STAT_W-1:0]  = {(DW-STAT_W){i_read_n | i_chip_select_n
                                          | i_readback_mode}}; // see RULE7
endmodule // aof_top

// ==========================================================================
// Two-entry buffer
// ==========================================================================
module aof_buf2
#(
    parameter W = 16
)
(
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire         i_valid,
    output wire         o_ready,
    input  wire [W-1:0] i_data,
    output wire         o_valid,
    input  wire         i_ready,
    output wire [W-1:0] o_data
);
    reg [W-1:0] mem_reg [0:1];
    reg         wp_reg;
    reg         rp_reg;
    reg [1:0]   cnt_reg;
    wire        wr;
    wire        rd;
    assign o_ready = (cnt_reg != 2'h2);
    assign o_valid = (cnt_reg != 2'h0);
    assign wr      = i_valid & o_ready;
    assign rd      = o_valid & i_ready;
    assign o_data  = mem_reg[rp_reg];
    // Pointers and occupancy; a stalled reader lets it fill.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
            mem_reg[0] <= {W{1'b0}};
            mem_reg[1] <= {W{1'b0}};
        end
        else
        begin
            if (wr)
            begin
                mem_reg[wp_reg] <= i_data;
                wp_reg          <= ~wp_reg;
            end
            if (rd)
                rp_reg <= ~rp_reg;
            cnt_reg <= cnt_reg + {1'b0, wr} - {1'b0, rd};
        end
    end
endmodule // aof_buf2

// ===== tb/aof_top_sva.sv
/* Checker of enables, busy timing and shutdown.
   Assumes it is bound to aof_top and sees its ports only. */
`timescale 1ns/100ps
module aof_chk (
    input wire        i_clk,
    input wire        i_rst_n,
    input wire        i_chip_select_n,
    input wire        i_read_n,
    input wire        i_convert_start_n,
    input wire        i_power_down_n,
    input wire        i_readback_mode,
    input wire [15:0] o_data_oe_n,
    input wire        o_busy_n,
    input wire        o_sample,
    input wire        o_nap,
    input wire        o_sleep,
    input wire        o_word_valid
);
    // ========================================
    // Helper counters
    // Busy low time, and time since busy last rose (saturates at 300).
    // The rest of the sample cycle after busy rises is 95 cycles long.
    logic [7:0] low_cnt;
    logic [8:0] gap_cnt;
    always @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
        begin
            low_cnt <= 8'h00;
            gap_cnt <= 9'h12C;
        end
        else
        begin
            low_cnt <= o_busy_n ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
            gap_cnt <= $rose(o_busy_n) ? 9'h000 : gap_cnt + {8'h00, gap_cnt != 9'h12C};
        end
    // ========================================
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_start;
        $fell(i_convert_start_n) && !i_chip_select_n && i_power_down_n && !i_readback_mode;
    endsequence
    sequence s_acq;
        o_sample [*8] ##1 o_sample [*7] ##1 !o_sample;
    endsequence
    property p_oe;
        !i_readback_mode |-> o_data_oe_n == ((i_chip_select_n || i_read_n) ? 16'hFFFF : 16'h0000);
    endproperty
    a_oe: assert property (p_oe) else $error("enable mismatch");
    property p_rb_low;
        i_readback_mode |-> o_data_oe_n[8:0] == 9'h1FF;
    endproperty
    a_rb_low: assert property (p_rb_low) else $error("low pins driven");
    property p_rb_top;
        i_readback_mode && !i_chip_select_n && !i_read_n |-> o_data_oe_n[15:9] == 7'h00;
    endproperty
    a_rb_top: assert property (p_rb_top) else $error("status pins idle");
    property p_start;
        s_start ##0 (o_busy_n && gap_cnt >= 9'h05E && !o_nap && !o_sleep) |=> !o_busy_n;
    endproperty
    a_start: assert property (p_start) else $error("start lost");
    property p_acq;
        $fell(o_busy_n) && !i_readback_mode |-> s_acq;
    endproperty
    a_acq: assert property (p_acq) else $error("acquire length");
    property p_len;
        $rose(o_busy_n) && !i_readback_mode |-> low_cnt >= 8'h96 && o_word_valid;
    endproperty
    a_len: assert property (p_len) else $error("busy too short");
    property p_nap;
        $fell(i_power_down_n) && !i_chip_select_n |=> o_nap && !o_sleep;
    endproperty
    a_nap: assert property (p_nap) else $error("nap not set");
    property p_sleep;
        $fell(i_power_down_n) && i_chip_select_n |=> o_sleep && !o_nap;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not set");
    property p_wake;
        $rose(i_power_down_n) |=> !o_nap && !o_sleep;
    endproperty
    a_wake: assert property (p_wake) else $error("still shut");
    property p_hold;
        !i_power_down_n && o_busy_n && !i_readback_mode |=> o_busy_n;
    endproperty
    a_hold: assert property (p_hold) else $error("start in shutdown");
endmodule // aof_chk
bind aof_top aof_chk u_aof_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_chip_select_n(i_chip_select_n), .i_read_n(i_read_n),
    .i_convert_start_n(i_convert_start_n), .i_power_down_n(i_power_down_n),
    .i_readback_mode(i_readback_mode), .o_data_oe_n(o_data_oe_n), .o_busy_n(o_busy_n),
    .o_sample(o_sample), .o_nap(o_nap), .o_sleep(o_sleep), .o_word_valid(o_word_valid));

// ===== tb/aof_host_model.sv
/* Host model that drains converter words, stalling at random.
   Assumes one clock; i_stall holds the host off. */
`timescale 1ns/100ps
module aof_host_model (
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire         i_valid,
    input  wire  [15:0] i_data,
    input  wire         i_stall,
    output logic        o_ready,
    output logic        o_taken,
    output logic [15:0] o_word
);
    // ========================================
    // Drain logic
    // Ready only after a word has stood a cycle, never twice in a row.
    always @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
        begin
            o_ready <= 1'b0;
            o_taken <= 1'b0;
            o_word  <= 16'h0000;
        end
        else
        begin
            o_taken <= o_ready && i_valid;
            o_word  <= i_data;
            o_ready <= i_valid && !o_ready && !i_stall && $urandom_range(1, 0);
        end
endmodule // aof_host_model

// ===== tb/tb.sv
/* Bench comparing the converter block with a queue model.
   Assumes the host model drains words and the checker is bound. */
`timescale 1ns/100ps
module tb;
    logic        clk, rst_n, cs_n, rd_n, conv_n, pd_n, pol, rb, stall, rdy, taken;
    logic        busy_n, smp, nap, slp, vld;
    logic [6:0]  st;
    logic [3:0]  mux;
    logic [11:0] raw;
    logic [15:0] data, oe_n, word;
    int          fail_count, checks_done, s;
    int          q[$];
    aof_top u_aof_top (.i_clk(clk), .i_rst_n(rst_n), .i_chip_select_n(cs_n), .i_read_n(rd_n),
        .i_convert_start_n(conv_n), .i_power_down_n(pd_n), .i_polarity_select(pol),
        .i_readback_mode(rb), .i_sequencer_status_word(st), .i_mux_addr(mux),
        .i_raw_result(raw), .i_host_ready(rdy), .o_data(data), .o_data_oe_n(oe_n),
        .o_busy_n(busy_n), .o_sample(smp), .o_nap(nap), .o_sleep(slp), .o_word_valid(vld));
    aof_host_model u_aof_host_model (.i_clk(clk), .i_rst_n(rst_n), .i_valid(vld),
        .i_data(data), .i_stall(stall), .o_ready(rdy), .o_taken(taken), .o_word(word));
    // Clock, and a watchdog well past the expected run of some 3600 cycles.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        test_done;
    end
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Every drained word is compared with the model's oldest word.
    always @(posedge clk)
        if (taken)
            check(word, q.size() ? q.pop_front() : 17'h10000);
    // One conversion with a refused restart inside it; model word queued.
    task automatic conv(input int r, input int m, input int p);
        @(posedge clk);
        {raw, mux, pol, cs_n, rd_n, conv_n} <= {r[11:0], m[3:0], p[0], 3'b010};
        @(posedge clk);
        conv_n <= 1'b1;
        repeat (20) @(posedge clk);
        conv_n <= 1'b0;
        @(posedge clk);
        conv_n <= 1'b1;
        q.push_back(m * 4096 + (p ? (r + 2048) % 4096 : r));
        repeat (280) @(posedge clk);
    endtask
    initial
    begin
        {rst_n, cs_n, rd_n, conv_n, pd_n, pol, rb, stall, st, mux, raw} = 31'h3C000000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        s = $urandom(30374);
        for (int i = 0; i < 6; i++)
            conv(i == 1 ? 4095 : i ? $urandom % 4096 : 0, $urandom % 16, i % 2);
        $display("conversions done");
        stall <= 1'b1;
        for (int i = 0; i < 3; i++)
            conv($urandom % 4096, $urandom % 16, i % 2);
        @(negedge clk);
        check(busy_n, 1'b0);
        @(posedge clk);
        stall <= 1'b0;
        repeat (400) @(posedge clk);
        check(q.size(), 0);
        $display("buffer stall done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            {cs_n, rd_n} <= i[1:0];
            @(negedge clk);
            check(oe_n, i ? 16'hFFFF : 16'h0000);
        end
        $display("enables done");
        @(posedge clk);
        st <= $urandom % 128;
        {rb, cs_n, rd_n} <= 3'b100;
        repeat (3) @(negedge clk);
        check(oe_n, 16'h01FF);
        check(data, {st, 9'h000});
        @(posedge clk);
        rd_n <= 1'b1;
        @(negedge clk);
        check(oe_n, 16'hFFFF);
        rb <= 1'b0;
        $display("readback done");
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            {cs_n, rd_n, pd_n} <= {i[0], 2'b10};
            repeat (3) @(posedge clk);
            // Chip select goes low for the start so that only shutdown can refuse it.
            {cs_n, conv_n} <= 2'b00;
            @(posedge clk);
            conv_n <= 1'b1;
            repeat (3) @(negedge clk);
            check({nap, slp, busy_n}, {!i[0], i[0], 1'b1});
            @(posedge clk);
            pd_n <= 1'b1;
            repeat (21) @(negedge clk);
            check({nap, slp}, 2'b00);
        end
        // Reference settling after Sleep is not modelled; only the logic wake time is kept.
        conv($urandom % 4096, $urandom % 16, 1);
        repeat (100) @(posedge clk);
        check(q.size(), 0);
        $display("shutdown done");
        test_done;
    end
endmodule // tb
